//--- inc/scs_defs.svh
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// Servo period codes in microseconds.
`define SCS_PERIOD_500US        16'h01F4
`define SCS_PERIOD_1000US       16'h03E8
`define SCS_PERIOD_2000US       16'h07D0
`define SCS_PERIOD_4000US       16'h0FA0
`define SCS_PERIOD_RESET        16'h03E8

// Slice lengths in nanoseconds and the clock period.
`define SCS_SLICE_250US_NS      250000
`define SCS_SLICE_500US_NS      500000
`define SCS_SLICE_1MS_NS        1000000
`define SCS_CLK_NS              8
`define SCS_SLICE_250US_CYC     (`SCS_SLICE_250US_NS / `SCS_CLK_NS)
`define SCS_SLICE_500US_CYC     (`SCS_SLICE_500US_NS / `SCS_CLK_NS)
`define SCS_SLICE_1MS_CYC       (`SCS_SLICE_1MS_NS / `SCS_CLK_NS)

// Station limits per period: axes, drives, inverters, stations.
`define SCS_LIM_500_AXES        8
`define SCS_LIM_500_DRV         4
`define SCS_LIM_500_INV         4
`define SCS_LIM_500_STA         4
`define SCS_LIM_1000_AXES       16
`define SCS_LIM_1000_DRV        8
`define SCS_LIM_1000_INV        8
`define SCS_LIM_1000_STA        8
`define SCS_LIM_2000_AXES       16
`define SCS_LIM_2000_DRV        16
`define SCS_LIM_2000_INV        8
`define SCS_LIM_2000_STA        16
`define SCS_LIM_4000_AXES       32
`define SCS_LIM_4000_DRV        30
`define SCS_LIM_4000_INV        8
`define SCS_LIM_4000_STA        30

`define SCS_NUM_AXES            32
`define SCS_NUM_PROCS           14

`endif

//--- inc/scs_pkg.sv
package scs_pkg;

    typedef enum logic [1:0]
    {
        SCS_P500,
        SCS_P1000,
        SCS_P2000,
        SCS_P4000
    } scs_period_t;

    typedef enum logic [2:0]
    {
        SCS_ST_IDLE,
        SCS_ST_BUF,
        SCS_ST_MEASURED_POSITION,
        SCS_ST_DEMANDED_POSITION,
        SCS_ST_LOOP,
        SCS_ST_REF,
        SCS_ST_ERR
    } scs_step_t;

    // Per-slice activity strobes given to the process engines.
    typedef struct packed
    {
        logic motion;
        logic low_prio;
        logic high_prio;
        logic indicator;
        logic comms;
    } scs_slice_act_t;

    // Step strobe handed to the axis datapath.
    typedef struct packed
    {
        logic       valid;
        scs_step_t  step;
        logic [4:0] axis;
    } scs_axis_step_t;

endpackage : scs_pkg

//--- logic/scs_scheduler.sv
`timescale 1ns/1ns
// Contract
// - Each cycle has four equal slices: 250us at 0.5/1ms, 500us at 2ms, 1ms at 4ms.
// - Slice one motion then low priority; two high priority; four external comms.
// - Slice three refreshes indicators, high priority, motion again only at 0.5ms.
// - At 0.5ms period a motion sequence starts every 0.5ms, slices one and three.
// - At 1ms period motion runs once per cycle in slice one only.
// - At 2ms period motion runs once every 2ms in slice one.
// - At 4ms period motion runs once every 4ms in slice one.
// - Servo period accepts only 0.5, 1, 2 or 4 ms.
// - Servo period defaults to 1000 microseconds.
// - A new servo period takes effect only after restart.
// - Drive slaves count as axes; inverter slaves do not.
// - Inconsistent period and slaves makes slave detection fail.
// - Up to fourteen program processes run concurrently within the slices.
// - Motion sequence handles all 32 axes through six ordered steps.
// - Issued motion commands are buffered; execution begins at next motion sequence.
// - Completed movement removes its command, freeing the buffer entry.
// - Following error over limit clears watchdog, servo off, cancels move; a restart in the same cycle keeps servo on.
`include "scs_defs.svh"
module scs_scheduler
    import scs_pkg::*;
#(
    parameter int NAXES    = `SCS_NUM_AXES,
    parameter int NPROCS   = `SCS_NUM_PROCS,
    parameter int SLICE250 = `SCS_SLICE_250US_CYC,
    parameter int SLICE500 = `SCS_SLICE_500US_CYC,
    parameter int SLICE1MS = `SCS_SLICE_1MS_CYC
)
(
    // Clock and reset.
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // Period setting and restart.
    input  wire logic [15:0]        period_wr_data,
    input  wire logic               period_wr,
    input  wire logic               restart,
    // Slave census from the fieldbus.
    input  wire logic [5:0]         drive_count,
    input  wire logic [5:0]         inverter_count,
    // Program processes.
    input  wire logic [NPROCS-1:0]  proc_ready,
    // Motion commands.
    input  wire logic [NAXES-1:0]   cmd_issue,
    input  wire logic [NAXES-1:0]   move_done,
    input  wire logic [NAXES-1:0]   fe_over_limit,
    input  wire logic               axis_step_done,
    // Schedule outputs.
    output scs_slice_act_t          slice_act,
    output logic [1:0]              slice_idx,
    output logic [15:0]             period_active,
    output logic [15:0]             period_pending,
    output logic                    period_wr_err,
    output logic [NPROCS-1:0]       proc_grant,
    output scs_axis_step_t          axis_step,
    output logic [NAXES-1:0]        buf_busy,
    output logic [NAXES-1:0]        buf_exec,
    output logic [NAXES-1:0]        servo_on,
    output logic                    drive_enable_watchdog,
    output logic [5:0]              axis_count,
    output logic                    slave_detect_ok
);

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic period_legal(input logic [15:0] v);
        return v == `SCS_PERIOD_500US || v == `SCS_PERIOD_1000US ||
               v == `SCS_PERIOD_2000US || v == `SCS_PERIOD_4000US;
    endfunction : period_legal

    function automatic scs_period_t period_code(input logic [15:0] v);
        case (v)
            `SCS_PERIOD_500US:  return SCS_P500;
            `SCS_PERIOD_2000US: return SCS_P2000;
            `SCS_PERIOD_4000US: return SCS_P4000;
            default:            return SCS_P1000;
        endcase
    endfunction : period_code

    logic [15:0]  pend_q;
    logic [15:0]  act_q;
    logic         wr_err_q;
    scs_period_t  mode;

    // Illegal values are dropped and flagged, the pending value stands.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pend_q   <= `SCS_PERIOD_RESET;
            wr_err_q <= 1'b0;
        end
        else if (period_wr)
        begin
            wr_err_q <= !period_legal(period_wr_data);
            if (period_legal(period_wr_data))
                pend_q <= period_wr_data;
        end
    end

    // The schedule reads only the active copy, loaded at restart.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            act_q <= `SCS_PERIOD_RESET;
        else if (restart)
            act_q <= pend_q;
    end

    assign mode           = period_code(act_q);
    assign period_active  = act_q;
    assign period_pending = pend_q;
    assign period_wr_err  = wr_err_q;

    ////////////////////////////////////////////////////////////////////////////

    logic [31:0] tick_q;
    logic [31:0] slice_len;
    logic [1:0]  slice_q;
    logic        boundary;

    always_comb
    begin
        case (mode)
            SCS_P2000: slice_len = 32'(SLICE500);
            SCS_P4000: slice_len = 32'(SLICE1MS);
            default:   slice_len = 32'(SLICE250);
        endcase
    end

    assign boundary = (tick_q == slice_len - 32'd1);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            tick_q <= 32'h0000_0000;
        else if (restart || boundary)
            tick_q <= 32'h0000_0000;
        else
            tick_q <= tick_q + 32'd1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            slice_q <= 2'h0;
        else if (restart)
            slice_q <= 2'h0;
        else if (boundary)
            slice_q <= slice_q + 2'd1;
    end

    assign slice_idx = slice_q;

    logic motion_slice;
    logic motion_start;

    always_comb
    begin
        slice_act = '0;
        case (slice_q)
            2'd0:
            begin
                slice_act.motion   = 1'b1;
                slice_act.low_prio = 1'b1;
            end
            2'd1: slice_act.high_prio = 1'b1;
            2'd2:
            begin
                slice_act.indicator = 1'b1;
                slice_act.high_prio = 1'b1;
                slice_act.motion    = (mode == SCS_P500);
            end
            default: slice_act.comms = 1'b1;
        endcase
    end

    assign motion_slice = slice_act.motion;
    assign motion_start = motion_slice && tick_q == 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////

    // Processes 12 and 13 (0-based) are high priority; the rest share low time.
    localparam int NHI = 2;

    always_comb
    begin
        proc_grant = '0;
        for (int i = 0; i < NPROCS; i++)
        begin
            if (i >= NPROCS - NHI)
                proc_grant[i] = proc_ready[i] && slice_act.high_prio;
            else
                proc_grant[i] = proc_ready[i] && slice_act.low_prio;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Each step covers every axis before the next step begins.
    scs_step_t   step_q;
    logic [4:0]  axis_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            step_q <= SCS_ST_IDLE;
            axis_q <= 5'h0;
        end
        else
        begin
            case (step_q)
                SCS_ST_IDLE:
                    if (motion_start)
                    begin
                        step_q <= SCS_ST_BUF;
                        axis_q <= 5'h0;
                    end
                SCS_ST_BUF, SCS_ST_MEASURED_POSITION, SCS_ST_DEMANDED_POSITION, SCS_ST_LOOP, SCS_ST_REF, SCS_ST_ERR:
                    if (axis_step_done)
                    begin
                        if (axis_q == 5'(NAXES - 1))
                        begin
                            axis_q <= 5'h0;
                            step_q <= (step_q == SCS_ST_ERR) ? SCS_ST_IDLE
                                                             : scs_step_t'(step_q + 3'd1);
                        end
                        else
                            axis_q <= axis_q + 5'd1;
                    end
                default: step_q <= SCS_ST_IDLE;
            endcase
        end
    end

    assign axis_step.valid = (step_q != SCS_ST_IDLE);
    assign axis_step.step  = step_q;
    assign axis_step.axis  = axis_q;

    ////////////////////////////////////////////////////////////////////////////

    logic seq_begin;
    assign seq_begin = motion_start && step_q == SCS_ST_IDLE;

    genvar g;
    generate
        for (g = 0; g < NAXES; g++)
        begin : g_axis
            logic busy_q;
            logic exec_q;
            logic servo_q;
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    busy_q  <= 1'b0;
                    exec_q  <= 1'b0;
                    servo_q <= 1'b1;
                end
                else
                begin
                    if (fe_over_limit[g])
                    begin
                        servo_q <= 1'b0;
                        busy_q  <= 1'b0;
                        exec_q  <= 1'b0;
                    end
                    else if (move_done[g] && exec_q)
                    begin
                        busy_q <= cmd_issue[g];
                        exec_q <= 1'b0;
                    end
                    else
                    begin
                        if (cmd_issue[g] && servo_q)
                            busy_q <= 1'b1;
                        if (seq_begin && busy_q)
                            exec_q <= 1'b1;
                    end
                    if (restart)
                        servo_q <= 1'b1;
                end
            end
            assign buf_busy[g] = busy_q;
            assign buf_exec[g] = exec_q;
            assign servo_on[g] = servo_q;
        end
    endgenerate

    // Watchdog drops on any following error and stays off until restart.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            drive_enable_watchdog <= 1'b1;
        else if (|fe_over_limit)
            drive_enable_watchdog <= 1'b0;
        else if (restart)
            drive_enable_watchdog <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////

    // Inverters are peripherals and never enter the axis count.
    assign axis_count = drive_count;

    logic       ok_d;
    logic [6:0] stations;
    assign stations = {1'b0, drive_count} + {1'b0, inverter_count};

    always_comb
    begin
        case (mode)
            SCS_P500:  ok_d = drive_count <= `SCS_LIM_500_DRV && inverter_count <= `SCS_LIM_500_INV
                              && stations <= `SCS_LIM_500_STA;
            SCS_P1000: ok_d = drive_count <= `SCS_LIM_1000_DRV
                              && inverter_count <= `SCS_LIM_1000_INV
                              && stations <= `SCS_LIM_1000_STA;
            SCS_P2000: ok_d = drive_count <= `SCS_LIM_2000_DRV
                              && inverter_count <= `SCS_LIM_2000_INV
                              && stations <= `SCS_LIM_2000_STA;
            default:   ok_d = drive_count <= `SCS_LIM_4000_DRV
                              && inverter_count <= `SCS_LIM_4000_INV
                              && stations <= `SCS_LIM_4000_STA;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            slave_detect_ok <= 1'b0;
        else
            slave_detect_ok <= ok_d;
    end

endmodule : scs_scheduler

//--- verification/scs_bus_model.sv
`timescale 1ns/1ns
module scs_bus_model
    import scs_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           resetn,
    input wire scs_axis_step_t axis_step,
    input wire logic           slow,
    input wire logic [5:0]     drv_set,
    input wire logic [5:0]     inv_set,
    output logic               axis_step_done,
    output logic [5:0]         drive_count,
    output logic [5:0]         inverter_count
);
    int wait_q;
    // Drives and inverters are reported apart so only drives become axes.
    always_ff @(posedge clk_sys)
    begin
        drive_count    <= drv_set;
        inverter_count <= inv_set;
    end
    // Each step is answered once; slow mode stretches the datapath reply.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            axis_step_done <= 1'b0;
            wait_q         <= 0;
        end
        else
        begin
            axis_step_done <= 1'b0;
            if (axis_step.valid && !axis_step_done)
            begin
                if (wait_q >= (slow ? 3 : 1))
                begin
                    axis_step_done <= 1'b1;
                    wait_q         <= 0;
                end
                else
                    wait_q <= wait_q + 1;
            end
        end
    end
endmodule : scs_bus_model

//--- verification/scs_sched_chk.sv
`timescale 1ns/1ns
`include "scs_defs.svh"
module scs_sched_chk
    import scs_pkg::*;
#(
    parameter int NAXES    = 32,
    parameter int NPROCS   = 14,
    parameter int SLICE250 = 8,
    parameter int SLICE500 = 16,
    parameter int SLICE1MS = 32
)
(
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic [15:0]       period_wr_data,
    input wire logic              period_wr,
    input wire logic              restart,
    input wire logic [5:0]        drive_count,
    input wire logic [NPROCS-1:0] proc_ready,
    input wire logic [NAXES-1:0]  fe_over_limit,
    input wire scs_slice_act_t    slice_act,
    input wire logic [1:0]        slice_idx,
    input wire logic [15:0]       period_active,
    input wire logic [15:0]       period_pending,
    input wire logic              period_wr_err,
    input wire logic [NPROCS-1:0] proc_grant,
    input wire scs_axis_step_t    axis_step,
    input wire logic [NAXES-1:0]  servo_on,
    input wire logic              drive_enable_watchdog,
    input wire logic [5:0]        axis_count
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Cycles spent in the current slice; restart restarts the timebase.
    int         cnt_q;
    logic [1:0] last_q;
    int         slen;
    wire legal = period_wr_data inside {`SCS_PERIOD_500US, `SCS_PERIOD_1000US,
                                        `SCS_PERIOD_2000US, `SCS_PERIOD_4000US};
    assign slen = (period_active == `SCS_PERIOD_4000US) ? SLICE1MS :
                  (period_active == `SCS_PERIOD_2000US) ? SLICE500 : SLICE250;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q  <= 0;
            last_q <= 2'd0;
        end
        else
        begin
            last_q <= slice_idx;
            cnt_q  <= restart ? 0 : (slice_idx != last_q) ? 1 : cnt_q + 1;
        end
    end
    sequence s_fresh_start;
        slice_idx == 2'd0 && drive_enable_watchdog && (&servo_on);
    endsequence
    a_slice_len: assert property (slice_idx != last_q && !$past(restart)
        |-> cnt_q == slen)
        else $error("slice length wrong");
    a_slice_order: assert property ($changed(slice_idx) && !$past(restart)
        |-> slice_idx == $past(slice_idx) + 2'd1)
        else $error("slice order broken");
    a_motion_slot: assert property (slice_act.motion == (slice_idx == 2'd0
        || (slice_idx == 2'd2 && period_active == `SCS_PERIOD_500US)))
        else $error("motion slot wrong");
    a_slice_roles: assert property (slice_act.high_prio == (slice_idx inside {2'd1, 2'd2})
        && slice_act.indicator == (slice_idx == 2'd2)
        && slice_act.low_prio == (slice_idx == 2'd0) && slice_act.comms == (slice_idx == 2'd3))
        else $error("slice roles wrong");
    a_period_reject: assert property (period_wr && !legal
        |=> period_wr_err && $stable(period_pending))
        else $error("illegal period taken");
    a_period_take: assert property (period_wr && legal
        |=> !period_wr_err && period_pending == $past(period_wr_data))
        else $error("legal period lost");
    a_period_hold: assert property (!restart |=> $stable(period_active))
        else $error("period changed without restart");
    a_restart_load: assert property (restart
        |=> s_fresh_start and period_active == $past(period_pending))
        else $error("restart load wrong");
    a_fe_stop: assert property (|fe_over_limit && !restart
        |=> !drive_enable_watchdog && (servo_on & $past(fe_over_limit)) == '0)
        else $error("following error not handled");
    a_axis_count: assert property (axis_count == drive_count)
        else $error("axis count wrong");
    a_grant_ready: assert property ((proc_grant & ~proc_ready) == '0)
        else $error("grant without ready");
    a_seq_begin: assert property ($rose(axis_step.valid)
        |-> axis_step.step == SCS_ST_BUF && axis_step.axis == 5'd0 && $past(slice_act.motion))
        else $error("sequence start wrong");
endmodule : scs_sched_chk
bind scs_scheduler scs_sched_chk #(.NAXES(NAXES), .NPROCS(NPROCS), .SLICE250(SLICE250),
    .SLICE500(SLICE500), .SLICE1MS(SLICE1MS)) i_scs_sched_chk (.clk_sys, .resetn,
    .period_wr_data, .period_wr, .restart, .drive_count, .proc_ready, .fe_over_limit,
    .slice_act, .slice_idx, .period_active, .period_pending, .period_wr_err, .proc_grant,
    .axis_step, .servo_on, .drive_enable_watchdog, .axis_count);

//--- verification/scs_scheduler_tb_top.sv
`timescale 1ns/1ns
module scs_scheduler_tb_top
    import scs_pkg::*;
;
    logic           clk_sys, resetn, period_wr, restart, axis_step_done, slow;
    logic [15:0]    period_wr_data, period_active, period_pending;
    logic [5:0]     drive_count, inverter_count, drv_set, inv_set, axis_count;
    logic [13:0]    proc_ready, proc_grant;
    logic [31:0]    cmd_issue, move_done, fe_over_limit, buf_busy, buf_exec, servo_on;
    scs_slice_act_t slice_act;
    scs_axis_step_t axis_step;
    logic [1:0]     slice_idx;
    logic           period_wr_err, drive_enable_watchdog, slave_detect_ok;
    int             n_fail, check_count;

    scs_scheduler #(.SLICE250(8), .SLICE500(16), .SLICE1MS(32)) i_scs_scheduler (
        .clk_sys, .resetn, .period_wr_data, .period_wr, .restart, .drive_count,
        .inverter_count, .proc_ready, .cmd_issue, .move_done, .fe_over_limit,
        .axis_step_done, .slice_act, .slice_idx, .period_active, .period_pending,
        .period_wr_err, .proc_grant, .axis_step, .buf_busy, .buf_exec, .servo_on,
        .drive_enable_watchdog, .axis_count, .slave_detect_ok);
    scs_bus_model i_scs_bus_model (.clk_sys, .resetn, .axis_step, .slow, .drv_set,
        .inv_set, .axis_step_done, .drive_count, .inverter_count);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic wr_period(input logic [15:0] v);
        period_wr      = 1'b1;
        period_wr_data = v;
        cyc(1);
        period_wr = 1'b0;
        cyc(1);
    endtask : wr_period
    task automatic do_restart;
        restart = 1'b1;
        cyc(1);
        restart = 1'b0;
    endtask : do_restart
    task automatic t_periods;
        logic [15:0] per [4] = '{16'h07D0, 16'h0FA0, 16'h03E8, 16'h01F4};
        int          len [4] = '{16, 32, 8, 8};
        int          n;
        wr_period(16'h05DC);
        chk(period_wr_err, 1'b1);
        chk(period_pending, 16'h03E8);
        for (int i = 0; i < 4; i++)
        begin
            proc_ready = 14'h3001 << i;
            wr_period(per[i]);
            chk(period_wr_err, 1'b0);
            chk(period_active, i == 0 ? 16'h03E8 : per[(i + 3) % 4]);
            do_restart();
            chk(period_active, per[i]);
            for (int s = 0; s < 4; s++)
            begin
                chk(slice_idx, s);
                chk(slice_act.motion, s == 0 || (s == 2 && i == 3));
                chk(slice_act.comms, s == 3);
                chk(proc_grant, proc_ready & (s == 0 ? 14'h0FFF : s == 3 ? '0 : 14'h3000));
                n = 0;
                while (slice_idx === 2'(s) && n < 100)
                begin
                    n++;
                    cyc(1);
                end
                chk(n, len[i]);
            end
        end
    endtask : t_periods
    task automatic t_census;
        logic [5:0] d [4] = '{6'd4, 6'd4, 6'd5, 6'd0};
        logic [5:0] v [4] = '{6'd0, 6'd4, 6'd0, 6'd4};
        for (int i = 0; i < 4; i++)
        begin
            drv_set = d[i];
            inv_set = v[i];
            cyc(3);
            chk(axis_count, d[i]);
            chk(slave_detect_ok, d[i] + v[i] <= 4);
        end
        wr_period(16'h0FA0);
        do_restart();
        drv_set = 6'd22;
        inv_set = 6'd8;
        cyc(3);
        chk(axis_count, 6'd22);
        chk(slave_detect_ok, 1'b1);
        drv_set = 6'd23;
        cyc(3);
        chk(slave_detect_ok, 1'b0);
    endtask : t_census
    task automatic t_buffer;
        int n = 0;
        cmd_issue = 32'h0000_0028;
        cyc(1);
        cmd_issue = '0;
        chk(buf_busy[3], 1'b1);
        chk(buf_busy[5], 1'b1);
        while (buf_exec[3] !== 1'b1 && n < 3000)
        begin
            n++;
            cyc(1);
        end
        chk(buf_exec[3], 1'b1);
        move_done = 32'h0000_0008;
        cyc(1);
        move_done = '0;
        chk(buf_busy[3], 1'b0);
        fe_over_limit = 32'h0000_0020;
        cyc(1);
        fe_over_limit = '0;
        chk(servo_on, 32'hFFFF_FFDF);
        chk(drive_enable_watchdog, 1'b0);
        cmd_issue = 32'h0000_0020;
        cyc(1);
        cmd_issue = '0;
        chk(buf_busy[5], 1'b0);
        do_restart();
        chk(drive_enable_watchdog, 1'b1);
    endtask : t_buffer
    task automatic t_seq;
        int n = 0;
        int k = 0;
        while (axis_step.valid !== 1'b0 && n < 3000)
        begin
            n++;
            cyc(1);
        end
        while (axis_step.valid !== 1'b1 && n < 3000)
        begin
            n++;
            cyc(1);
        end
        chk({axis_step.step, axis_step.axis}, {SCS_ST_BUF, 5'd0});
        while (k < 192 && n < 3000)
        begin
            n++;
            cyc(1);
            if (axis_step_done === 1'b1)
            begin
                chk({axis_step.step, axis_step.axis}, {3'(1 + k / 32), 5'(k % 32)});
                k++;
            end
        end
        cyc(1);
        chk(axis_step.valid, 1'b0);
    endtask : t_seq

    initial
    begin
        resetn = 1'b0;
        {period_wr, restart, slow} = '0;
        period_wr_data = 16'h03E8;
        {drv_set, inv_set} = '0;
        proc_ready = 14'h3001;
        {cmd_issue, move_done, fe_over_limit} = '0;
        repeat (10) @(posedge clk_sys);
        #1 resetn = 1'b1;
        chk(period_active, 16'h03E8);
        chk(servo_on, 32'hFFFF_FFFF);
        t_periods();
        t_census();
        t_buffer();
        t_seq();
        slow = 1'b1;
        t_seq();
        results();
    end
    // A hang is cut short well after the roughly three thousand cycles the run needs.
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
endmodule : scs_scheduler_tb_top
